// *** shared/alfm_pkg.sv ***
// Package: types and constants for the layer-4 port and flag match stage
package alfm_pkg;

   // ---------------------------------------------------------------
   // Widths and encodings
   // ---------------------------------------------------------------
   localparam int PORT_W = 16;
   localparam int FLAG_N = 6;
   localparam logic [PORT_W-1:0] PORT_MAX = 16'hffff;

   // Flag bit positions in the flag vector
   localparam int FLG_FIN = 0;
   localparam int FLG_SYN = 1;
   localparam int FLG_RST = 2;
   localparam int FLG_PSH = 3;
   localparam int FLG_ACK = 4;
   localparam int FLG_URG = 5;

   // Port condition mode
   typedef enum logic [1:0] {
      ALFM_PM_ANY   = 2'h0,
      ALFM_PM_EXACT = 2'h1,
      ALFM_PM_RANGE = 2'h2
   } alfm_pmode_t;

   // Three-state flag condition
   typedef enum logic [1:0] {
      ALFM_FC_ANY   = 2'h0,
      ALFM_FC_CLEAR = 2'h1,
      ALFM_FC_SET   = 2'h2
   } alfm_fcond_t;

   // Entry protocol selection
   typedef enum logic [1:0] {
      ALFM_PR_OTHER = 2'h0,
      ALFM_PR_TCP   = 2'h1,
      ALFM_PR_UDP   = 2'h2
   } alfm_proto_t;

   // One port condition
   typedef struct packed {
      alfm_pmode_t mode;
      logic [PORT_W-1:0] lo;
      logic [PORT_W-1:0] hi;
   } alfm_pcond_t;

   // Whole filter_entry layer-4 setting
   typedef struct packed {
      alfm_proto_t proto;
      alfm_pcond_t src;
      alfm_pcond_t dst;
      alfm_fcond_t [FLAG_N-1:0] flag;
   } alfm_entry_t;

   // Parsed received frame header
   typedef struct packed {
      alfm_proto_t proto;
      logic [PORT_W-1:0] sport;
      logic [PORT_W-1:0] dport;
      logic [FLAG_N-1:0] flags;
   } alfm_frame_t;

endpackage : alfm_pkg

// *** rtl/alfm_port_cmp.sv ***
// Port condition compare: don't-care, exact value or inclusive range
`timescale 1ns/1ps
module alfm_port_cmp (
   // Condition
   input wire alfm_pkg::alfm_pcond_t cond_i,
   // Frame port number
   input wire logic [alfm_pkg::PORT_W-1:0] port_i,
   // Result
   output logic match_o,
   output logic bad_cfg_o
);
   import alfm_pkg::*;

   // Mode decode; an unknown mode never matches
   always_comb begin
      bad_cfg_o = 1'b0;
      unique case (cond_i.mode)
         ALFM_PM_ANY: begin
            match_o = 1'b1;
         end
         ALFM_PM_EXACT: begin
            match_o = (port_i == cond_i.lo);
         end
         ALFM_PM_RANGE: begin
            // Both ends inclusive; inverted bounds match nothing
            match_o = (port_i >= cond_i.lo) && (port_i <= cond_i.hi);
            bad_cfg_o = (cond_i.lo > cond_i.hi);
         end
         default: begin
            match_o = 1'b0;
            bad_cfg_o = 1'b1;
         end
      endcase
   end
endmodule : alfm_port_cmp

// *** rtl/alfm_flag_cmp.sv ***
// Three-state compare of one TCP header flag
`timescale 1ns/1ps
module alfm_flag_cmp (
   // Condition
   input wire alfm_pkg::alfm_fcond_t cond_i,
   // Frame flag
   input wire logic flag_i,
   // Result
   output logic match_o
);
   import alfm_pkg::*;

   // Clear rejects a set flag, set requires it, any ignores it
   always_comb begin
      unique case (cond_i)
         ALFM_FC_ANY: begin
            match_o = 1'b1;
         end
         ALFM_FC_CLEAR: begin
            match_o = ~flag_i;
         end
         ALFM_FC_SET: begin
            match_o = flag_i;
         end
         default: begin
            match_o = 1'b0;
         end
      endcase
   end
endmodule : alfm_flag_cmp

// *** rtl/alfm_matcher.sv ***
// Layer-4 source/destination port and TCP flag match stage of one filter_entry
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Behaviour
// R1: Source-port condition has don't-care, exact and range modes.
// R2: Exact source mode matches only a 16-bit equal source port.
// R3: Range source mode matches source ports inside the bounds.
// R4: Destination-port condition has don't-care, exact and range modes.
// R5: Exact destination mode matches only an equal destination port.
// R6: Range destination mode matches destination ports inside the bounds.
// R7: FIN condition: clear rejects set flag, set requires it, any ignores.
// R8: SYN condition: clear rejects set flag, set requires it, any ignores.
// R9: RST condition: clear rejects set flag, set requires it, any ignores.
// R10: PSH condition: clear rejects set flag, set requires it, any ignores.
// R11: ACK condition: clear rejects set flag, set requires it, any ignores.
// R12: URG condition: clear rejects set flag, set requires it, any ignores.
// R13: Port and flag checks apply only when entry protocol is TCP or UDP.
// R14: Range bounds are inclusive; lower bound must not exceed upper.
// R15: Hit only when every condition holds; don't-care counts as true.
// ---------------------------------------------------------------
module alfm_matcher (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Entry setting from management
   input wire alfm_pkg::alfm_entry_t entry_i,
   // Parsed received frame
   input wire logic frm_valid_i,
   input wire alfm_pkg::alfm_frame_t frame_i,
   // Match result
   output logic res_valid_o,
   output logic hit_o,
   output logic cfg_err_o
);
   import alfm_pkg::*;

   // ---------------------------------------------------------------
   // Condition compares
   // ---------------------------------------------------------------
   logic src_ok;
   logic dst_ok;
   logic src_bad;
   logic dst_bad;
   logic [FLAG_N-1:0] flag_ok;
   logic proto_ok;
   logic l4_on;
   logic all_ok;

   // Compares run every cycle; frm_valid_i alone qualifies the result
   // Source port: any, exact or inclusive range
   alfm_port_cmp u_src_cmp ( // [R1] [R2] [R3] [R14]
      .cond_i(entry_i.src),
      .port_i(frame_i.sport),
      .match_o(src_ok),
      .bad_cfg_o(src_bad)
   );

   // Destination port: any, exact or inclusive range
   alfm_port_cmp u_dst_cmp ( // [R4] [R5] [R6] [R14]
      .cond_i(entry_i.dst),
      .port_i(frame_i.dport),
      .match_o(dst_ok),
      .bad_cfg_o(dst_bad)
   );

   // An undefined condition code fails its flag rather than passing it
   // One three-state compare per TCP flag
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
         alfm_flag_cmp u_flag_cmp ( // [R7] [R8] [R9] [R10] [R11] [R12]
            .cond_i(entry_i.flag[gi]),
            .flag_i(frame_i.flags[gi]),
            .match_o(flag_ok[gi])
         );
      end
   endgenerate

   // Protocol gate and final AND of all conditions
   // A frame of the other layer-4 protocol never satisfies the entry
   always_comb begin
      l4_on = (entry_i.proto == ALFM_PR_TCP) || (entry_i.proto == ALFM_PR_UDP); // [R13]
      proto_ok = (frame_i.proto == entry_i.proto);
      if (!l4_on) begin
         // Layer-4 conditions unused: this stage is transparent
         all_ok = 1'b1; // [R13]
      end else if (entry_i.proto == ALFM_PR_TCP) begin
         all_ok = proto_ok && src_ok && dst_ok && (&flag_ok); // [R15]
      end else begin
         // Flags exist only in TCP headers
         all_ok = proto_ok && src_ok && dst_ok; // [R15]
      end
   end

   // ---------------------------------------------------------------
   // Result register
   // ---------------------------------------------------------------
   logic next_res_valid;
   logic next_hit;
   logic next_cfg_err;

   // Next result values
   // The error flag follows the entry every cycle, with or without frames
   always_comb begin
      next_res_valid = frm_valid_i;
      next_hit = frm_valid_i && all_ok; // [R15]
      next_cfg_err = l4_on && (src_bad || dst_bad); // [R14]
   end

   // Register result; one cycle latency
   // Reset clears the result so no stale hit leaves the stage
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         res_valid_o <= 1'b0;
         hit_o <= 1'b0;
         cfg_err_o <= 1'b0;
      end else begin
         res_valid_o <= next_res_valid;
         hit_o <= next_hit;
         cfg_err_o <= next_cfg_err;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Properties look at the inputs on the taking edge and at the result one edge later

   // TCP entry and TCP frame
   sequence s_tcp_frame;
      frm_valid_i && entry_i.proto == ALFM_PR_TCP && frame_i.proto == ALFM_PR_TCP;
   endsequence

   // Layer-4 entry and a frame of the same protocol
   sequence s_l4_frame;
      frm_valid_i && l4_on && frame_i.proto == entry_i.proto;
   endsequence

   // UDP entry and UDP frame; flag conditions take no part
   sequence s_udp_frame;
      frm_valid_i && entry_i.proto == ALFM_PR_UDP && frame_i.proto == ALFM_PR_UDP;
   endsequence

   // Flag part of a match as the entry's protocol sees it
   logic chk_flags_pass;
   assign chk_flags_pass = (entry_i.proto == ALFM_PR_UDP) || (&flag_ok);

   AST_SRC_EXACT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R2]
      frm_valid_i && l4_on && entry_i.src.mode == ALFM_PM_EXACT
      && frame_i.sport != entry_i.src.lo |=> !hit_o)
      else $error("exact source mismatch gave a hit");

   AST_SRC_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R3]
      frm_valid_i && l4_on && entry_i.src.mode == ALFM_PM_RANGE
      && (frame_i.sport < entry_i.src.lo || frame_i.sport > entry_i.src.hi) |=> !hit_o)
      else $error("source port outside range gave a hit");

   AST_DST_EXACT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R5]
      frm_valid_i && l4_on && entry_i.dst.mode == ALFM_PM_EXACT
      && frame_i.dport != entry_i.dst.lo |=> !hit_o)
      else $error("exact destination mismatch gave a hit");

   AST_DST_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R6]
      frm_valid_i && l4_on && entry_i.dst.mode == ALFM_PM_RANGE
      && (frame_i.dport < entry_i.dst.lo || frame_i.dport > entry_i.dst.hi) |=> !hit_o)
      else $error("destination port outside range gave a hit");

   AST_RANGE_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
      s_tcp_frame and (entry_i.src.mode == ALFM_PM_RANGE && frame_i.sport == entry_i.src.lo
      && entry_i.src.lo <= entry_i.src.hi && entry_i.dst.mode == ALFM_PM_ANY
      && (&flag_ok)) |=> hit_o)
      else $error("lower range bound did not match");

   AST_FLAG_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R7]
      s_tcp_frame and (entry_i.flag[FLG_FIN] == ALFM_FC_CLEAR && frame_i.flags[FLG_FIN])
      |=> !hit_o)
      else $error("set FIN matched a clear condition");

   AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R8]
      s_tcp_frame and (entry_i.flag[FLG_SYN] == ALFM_FC_SET && !frame_i.flags[FLG_SYN])
      |=> !hit_o)
      else $error("clear SYN matched a set condition");

   AST_NO_L4: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R13]
      frm_valid_i && entry_i.proto == ALFM_PR_OTHER |=> hit_o && res_valid_o)
      else $error("non layer-4 entry blocked a frame");

   AST_ALL_ANY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
      s_tcp_frame and (entry_i.src.mode == ALFM_PM_ANY && entry_i.dst.mode == ALFM_PM_ANY
      && entry_i.flag == '0) |=> hit_o)
      else $error("all don't-care entry missed a TCP frame");

   AST_HIT_VALID: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
      hit_o |-> res_valid_o && $past(frm_valid_i))
      else $error("hit without a frame");

   AST_SRC_ANY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1]
      s_l4_frame and (entry_i.src.mode == ALFM_PM_ANY && dst_ok && chk_flags_pass) |=> hit_o)
      else $error("don't-care source blocked a frame");

   AST_DST_ANY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R4]
      s_l4_frame and (entry_i.dst.mode == ALFM_PM_ANY && src_ok && chk_flags_pass) |=> hit_o)
      else $error("don't-care destination blocked a frame");

   AST_SRC_EQ_HIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R2]
      s_l4_frame and (entry_i.src.mode == ALFM_PM_EXACT && frame_i.sport == entry_i.src.lo
      && dst_ok && chk_flags_pass) |=> hit_o)
      else $error("equal source port missed");

   AST_DST_EQ_HIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R5]
      s_l4_frame and (entry_i.dst.mode == ALFM_PM_EXACT && frame_i.dport == entry_i.dst.lo
      && src_ok && chk_flags_pass) |=> hit_o)
      else $error("equal destination port missed");

   AST_SRC_IN_HIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R3]
      s_l4_frame and (entry_i.src.mode == ALFM_PM_RANGE && frame_i.sport >= entry_i.src.lo
      && frame_i.sport <= entry_i.src.hi && dst_ok && chk_flags_pass) |=> hit_o)
      else $error("source port inside range missed");

   AST_DST_IN_HIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R6]
      s_l4_frame and (entry_i.dst.mode == ALFM_PM_RANGE && frame_i.dport >= entry_i.dst.lo
      && frame_i.dport <= entry_i.dst.hi && src_ok && chk_flags_pass) |=> hit_o)
      else $error("destination port inside range missed");

   AST_SRC_BAD_MODE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1]
      frm_valid_i && l4_on
      && !(entry_i.src.mode inside {ALFM_PM_ANY, ALFM_PM_EXACT, ALFM_PM_RANGE}) |=> !hit_o)
      else $error("illegal source mode gave a hit");

   AST_CFG_ERR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
      l4_on && entry_i.src.mode == ALFM_PM_RANGE && entry_i.src.lo > entry_i.src.hi
      |=> cfg_err_o)
      else $error("inverted source range not flagged");

   AST_INV_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
      frm_valid_i && l4_on && entry_i.src.mode == ALFM_PM_RANGE
      && entry_i.src.lo > entry_i.src.hi |=> !hit_o)
      else $error("inverted source range gave a hit");

   AST_UDP_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R13]
      s_udp_frame and (src_ok && dst_ok) |=> hit_o)
      else $error("flag condition blocked a UDP frame");

   AST_PROTO_MISS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
      frm_valid_i && l4_on && frame_i.proto != entry_i.proto |=> !hit_o)
      else $error("frame of another protocol gave a hit");

   AST_RES_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
      frm_valid_i |=> res_valid_o)
      else $error("frame gave no result");

   AST_RES_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
      !frm_valid_i |=> !res_valid_o && !hit_o)
      else $error("result without a frame");

   AST_FIN_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R7]
      s_tcp_frame and (entry_i.flag[FLG_FIN] == ALFM_FC_SET && !frame_i.flags[FLG_FIN])
      |=> !hit_o)
      else $error("clear FIN matched a set condition");

   AST_SYN_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R8]
      s_tcp_frame and (entry_i.flag[FLG_SYN] == ALFM_FC_CLEAR && frame_i.flags[FLG_SYN])
      |=> !hit_o)
      else $error("set SYN matched a clear condition");

   AST_RST_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R9]
      s_tcp_frame and (entry_i.flag[FLG_RST] == ALFM_FC_CLEAR && frame_i.flags[FLG_RST])
      |=> !hit_o)
      else $error("set RST matched a clear condition");

   AST_RST_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R9]
      s_tcp_frame and (entry_i.flag[FLG_RST] == ALFM_FC_SET && !frame_i.flags[FLG_RST])
      |=> !hit_o)
      else $error("clear RST matched a set condition");

   AST_PSH_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R10]
      s_tcp_frame and (entry_i.flag[FLG_PSH] == ALFM_FC_CLEAR && frame_i.flags[FLG_PSH])
      |=> !hit_o)
      else $error("set PSH matched a clear condition");

   AST_PSH_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R10]
      s_tcp_frame and (entry_i.flag[FLG_PSH] == ALFM_FC_SET && !frame_i.flags[FLG_PSH])
      |=> !hit_o)
      else $error("clear PSH matched a set condition");

   AST_ACK_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
      s_tcp_frame and (entry_i.flag[FLG_ACK] == ALFM_FC_CLEAR && frame_i.flags[FLG_ACK])
      |=> !hit_o)
      else $error("set ACK matched a clear condition");

   AST_ACK_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
      s_tcp_frame and (entry_i.flag[FLG_ACK] == ALFM_FC_SET && !frame_i.flags[FLG_ACK])
      |=> !hit_o)
      else $error("clear ACK matched a set condition");

   AST_URG_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R12]
      s_tcp_frame and (entry_i.flag[FLG_URG] == ALFM_FC_CLEAR && frame_i.flags[FLG_URG])
      |=> !hit_o)
      else $error("set URG matched a clear condition");

   AST_URG_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R12]
      s_tcp_frame and (entry_i.flag[FLG_URG] == ALFM_FC_SET && !frame_i.flags[FLG_URG])
      |=> !hit_o)
      else $error("clear URG matched a set condition");

endmodule : alfm_matcher

// *** dv/alfm_frm_src.sv ***
// Frame source model: parsed received frames from the switch ports
`timescale 1ns/1ps
module alfm_frm_src (
   // Clock
   input wire logic clk_sys_i,
   // Parsed frame out
   output logic frm_valid_o,
   output alfm_pkg::alfm_frame_t frame_o
);
   import alfm_pkg::*;

   // Idle at time zero
   initial begin
      frm_valid_o = 1'b0;
      frame_o = '0;
   end

   // One frame, held over one sampling edge; call just after a rising edge
   task send(input alfm_frame_t f);
      frm_valid_o = 1'b1;
      frame_o = f;
      @(posedge clk_sys_i);
      #1;
      frm_valid_o = 1'b0;
      frame_o = ~f; // Released lines must not keep the last value
   endtask : send
endmodule : alfm_frm_src

// *** dv/alfm_matcher_tb.sv ***
// Self-checking testbench for the layer-4 port and flag match stage
`timescale 1ns/1ps
module alfm_matcher_tb;
   import alfm_pkg::*;

   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   alfm_entry_t entry_i = '0;
   logic frm_valid_i;
   alfm_frame_t frame_i;
   logic res_valid_o;
   logic hit_o;
   logic cfg_err_o;
   int num_errors = 0;
   int tests_run = 0;

   // Clock, 25 ns period
   always #12.5 clk_sys_i = ~clk_sys_i;

   alfm_frm_src alfm_frm_src_inst (
      .clk_sys_i(clk_sys_i),
      .frm_valid_o(frm_valid_i),
      .frame_o(frame_i)
   );

   alfm_matcher alfm_matcher_inst (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .entry_i(entry_i),
      .frm_valid_i(frm_valid_i),
      .frame_i(frame_i),
      .res_valid_o(res_valid_o),
      .hit_o(hit_o),
      .cfg_err_o(cfg_err_o)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   // Compare and count
   task check(input string what, input logic [1:0] seen, input logic [1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Verdict and end of run
   task results;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // Build one frame
   function automatic alfm_frame_t fr(alfm_proto_t p, logic [15:0] s, logic [15:0] d,
                                      logic [5:0] f);
      fr.proto = p;
      fr.sport = s;
      fr.dport = d;
      fr.flags = f;
   endfunction : fr

   // Build one port condition
   function automatic alfm_pcond_t pc(alfm_pmode_t m, logic [15:0] lo, logic [15:0] hi);
      pc.mode = m;
      pc.lo = lo;
      pc.hi = hi;
   endfunction : pc

   // One frame against the current entry: result pulse, hit, then idle
   task go(input string what, input alfm_frame_t f, input logic exp_hit);
      alfm_frm_src_inst.send(f);
      check(what, {res_valid_o, hit_o}, {1'b1, exp_hit});
      @(posedge clk_sys_i);
      #1;
      check("idle valid", {1'b0, res_valid_o}, 2'h0);
   endtask : go

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Exact, range and don't-care port modes at their boundaries
   task t_ports;
      entry_i = '0;
      entry_i.proto = ALFM_PR_UDP;
      entry_i.src = pc(ALFM_PM_EXACT, 16'hffff, 16'h0000);
      entry_i.dst = pc(ALFM_PM_RANGE, 16'h0100, 16'h01ff);
      go("rng lo", fr(ALFM_PR_UDP, 16'hffff, 16'h0100, 6'h00), 1'b1);
      go("rng hi", fr(ALFM_PR_UDP, 16'hffff, 16'h01ff, 6'h00), 1'b1);
      go("rng below", fr(ALFM_PR_UDP, 16'hffff, 16'h00ff, 6'h00), 1'b0);
      go("rng above", fr(ALFM_PR_UDP, 16'hffff, 16'h0200, 6'h00), 1'b0);
      go("exact off", fr(ALFM_PR_UDP, 16'hfffe, 16'h0150, 6'h00), 1'b0);
      check("cfg ok", {1'b0, cfg_err_o}, 2'h0);
      entry_i.src = pc(ALFM_PM_RANGE, 16'h0000, 16'h0000);
      entry_i.dst = pc(ALFM_PM_EXACT, 16'h0000, 16'hffff);
      go("src rng 0", fr(ALFM_PR_UDP, 16'h0000, 16'h0000, 6'h00), 1'b1);
      go("src rng 1", fr(ALFM_PR_UDP, 16'h0001, 16'h0000, 6'h00), 1'b0);
      go("dst ex off", fr(ALFM_PR_UDP, 16'h0000, 16'h0001, 6'h00), 1'b0);
      entry_i.src = pc(ALFM_PM_ANY, 16'h1234, 16'h0001);
      entry_i.dst = pc(ALFM_PM_ANY, 16'h4321, 16'h0001);
      go("any", fr(ALFM_PR_UDP, 16'h8000, 16'hffff, 6'h00), 1'b1);
   endtask : t_ports

   // Every flag under clear, set and don't-care conditions
   task t_flags;
      entry_i = '0;
      entry_i.proto = ALFM_PR_TCP;
      for (int i = 0; i < FLAG_N; i++) begin
         entry_i.flag[i] = ALFM_FC_CLEAR;
         go("clr ok", fr(ALFM_PR_TCP, 16'h0050, 16'h0050, ~(6'h01 << i)), 1'b1);
         go("clr bad", fr(ALFM_PR_TCP, 16'h0050, 16'h0050, 6'h01 << i), 1'b0);
         entry_i.flag[i] = ALFM_FC_SET;
         go("set ok", fr(ALFM_PR_TCP, 16'h0050, 16'h0050, 6'h01 << i), 1'b1);
         go("set bad", fr(ALFM_PR_TCP, 16'h0050, 16'h0050, ~(6'h01 << i)), 1'b0);
         entry_i.flag[i] = ALFM_FC_ANY;
         go("any flag", fr(ALFM_PR_TCP, 16'h0050, 16'h0050, 6'h01 << i), 1'b1);
      end
   endtask : t_flags

   // Protocol selection and an inverted range
   task t_proto;
      entry_i = '0;
      entry_i.src = pc(ALFM_PM_EXACT, 16'h0035, 16'h0000);
      go("other", fr(ALFM_PR_TCP, 16'h0001, 16'h0002, 6'h3f), 1'b1);
      entry_i.proto = ALFM_PR_UDP;
      entry_i.flag[FLG_SYN] = ALFM_FC_SET;
      go("udp flags", fr(ALFM_PR_UDP, 16'h0035, 16'h0002, 6'h00), 1'b1);
      go("udp vs tcp", fr(ALFM_PR_TCP, 16'h0035, 16'h0002, 6'h02), 1'b0);
      entry_i.proto = ALFM_PR_TCP;
      entry_i.src = pc(ALFM_PM_RANGE, 16'h0020, 16'h0010);
      go("inverted", fr(ALFM_PR_TCP, 16'h0018, 16'h0002, 6'h02), 1'b0);
      check("cfg err", {1'b0, cfg_err_o}, 2'h1);
      entry_i.src = pc(ALFM_PM_RANGE, 16'h0010, 16'h0020);
      go("tcp rng lo", fr(ALFM_PR_TCP, 16'h0010, 16'h0002, 6'h02), 1'b1);
      check("cfg clr", {1'b0, cfg_err_o}, 2'h0);
      entry_i.flag[FLG_URG] = alfm_fcond_t'(2'h3);
      go("bad flag code", fr(ALFM_PR_TCP, 16'h0010, 16'h0002, 6'h22), 1'b0);
      entry_i.flag[FLG_URG] = ALFM_FC_ANY;
      entry_i.src.mode = alfm_pmode_t'(2'h3);
      go("bad mode", fr(ALFM_PR_TCP, 16'h0010, 16'h0002, 6'h02), 1'b0);
      check("mode err", {1'b0, cfg_err_o}, 2'h1);
   endtask : t_proto

   // Reset in mid-run over a frame, then a frame after release
   task t_reset;
      entry_i = '0;
      rst_b_i = 1'b0;
      alfm_frm_src_inst.send(fr(ALFM_PR_TCP, 16'h0001, 16'h0002, 6'h00));
      check("rst frame", {res_valid_o, hit_o}, 2'h0);
      check("rst cfg", {1'b0, cfg_err_o}, 2'h0);
      rst_b_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      check("rst out", {res_valid_o, hit_o}, 2'h0);
      go("after rst", fr(ALFM_PR_TCP, 16'h0001, 16'h0002, 6'h00), 1'b1);
   endtask : t_reset

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   // Reset for 16 cycles, then the scenarios
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1;
      check("reset out", {res_valid_o, hit_o}, 2'h0);
      rst_b_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      check("release out", {res_valid_o, hit_o}, 2'h0);
      t_ports();
      t_flags();
      t_proto();
      t_reset();
      results();
   end

   // Cut a hang short well beyond the expected run
   initial begin
      #(25 * 2000);
      num_errors++;
      results();
   end
endmodule : alfm_matcher_tb
